// ==== design/fdcs_params.svh ====
// constants of the demodulator control and status block
// Function
// R1 - AFC runs unless tracking disable bit set
// R2 - squelch forces output one on weak signal
// R3 - freeze bit zero holds all monitoring values
// R4 - shared bus: answer only own 4-bit address
// R5 - master gives each slave a unique address
// R6 - 24-bit carrier offset, low byte first
// R7 - 8-bit unsigned filtered signal magnitude
// R8 - lock in status bit 0 and test point
// R9 - signal detect in status bit 1, test point
// R10 - status registers read-only, writes ignored
// R11 - test point carries carrier NCO MSB
// R12 - test point flags I/Q input saturation
// R13 - test points for bit timing, processing clock
// R14 - two 512-sample 8-bit traces, lock/detect trigger
// R15 - trace decimation and processing clock select
// R16 - symbols taken as one continuous-phase stream
// R17 - two-level: -1 gives 0, +1 gives 1
// R18 - 1/2/3-bit symbols sent MSB first
// R19 - four/eight-level low symbol mappings
// R20 - symbol spacing half index times rate
// R21 - eight-level upper symbols continue linear map
// R22 - alphabet field 00/01/10 selects 2/4/8 levels
// R23 - output mode bit: 0 direct, 1 shared bus
`ifndef FDCS_PARAMS_SVH
`define FDCS_PARAMS_SVH

// clock rates
`define FDCS_CLK_HZ 200_000_000
`define FDCS_PROC_HZ 80_000_000
`define FDCS_TPCLK_HALF ((`FDCS_CLK_HZ / (2 * `FDCS_PROC_HZ)) > 0 ? \
    (`FDCS_CLK_HZ / (2 * `FDCS_PROC_HZ)) : 1)

// register offsets
`define FDCS_A_CTRL 8'h08
`define FDCS_A_BADDR 8'h09
`define FDCS_A_OFS_LO 8'h0C
`define FDCS_A_OFS_MID 8'h0D
`define FDCS_A_OFS_HI 8'h0E
`define FDCS_A_MAG 8'h0F
`define FDCS_A_LOCK 8'h10
`define FDCS_A_TCTL 8'h11
`define FDCS_A_TDEC 8'h12
`define FDCS_A_TRA_LO 8'h13
`define FDCS_A_TRA_HI 8'h14
`define FDCS_A_TSTAT 8'h15
`define FDCS_A_TD1 8'h16
`define FDCS_A_TD2 8'h17

// reset values
`define FDCS_CTRL_RST 8'h80
`define FDCS_ZERO8 8'h00

// mode control fields
`define FDCS_F_MARY 1:0
`define FDCS_B_UNSIGNED 2
`define FDCS_B_SPINV 3
`define FDCS_B_BUSMODE 4
`define FDCS_B_AFC_DIS 5
`define FDCS_B_SQL 6
`define FDCS_B_RUN 7
`define FDCS_F_ADDR 3:0

// trace control fields
`define FDCS_F_SEL1 2:0
`define FDCS_F_SEL2 5:3
`define FDCS_B_TRIG 6
`define FDCS_B_FCLK 7
`define FDCS_SEL_MAX 3'h4

// trace buffer geometry
`define FDCS_TR_AW 9
`define FDCS_TR_LAST 9'h1FF

// symbol offsets and sizes per alphabet
`define FDCS_OFS2 5'h01
`define FDCS_OFS4 5'h03
`define FDCS_OFS8 5'h07
`define FDCS_NB1 2'h1
`define FDCS_NB2 2'h2
`define FDCS_NB3 2'h3

`endif

// ==== design/fdcs_pkg.sv ====
// types of the demodulator control and status block
package fdcs_pkg;

    // monitoring values from the signal path
    typedef struct packed {
        logic [23:0] offset;
        logic [7:0] magnitude;
        logic lock;
        logic detect;
    } fdcs_stat_type;

    typedef enum logic [1:0] {
        FDCS_M2 = 2'b00,
        FDCS_M4 = 2'b01,
        FDCS_M8 = 2'b10
    } fdcs_mary_type;

    typedef enum logic [1:0] {
        FDCS_CAP_IDLE = 2'b00,
        FDCS_CAP_ARMED = 2'b01,
        FDCS_CAP_RUN = 2'b10,
        FDCS_CAP_DONE = 2'b11
    } fdcs_cap_type;

endpackage

// ==== design/fdcs_trace_mem.sv ====
// trace sample memory, both traces side by side, registered read
`timescale 1ns/1ps
`default_nettype none
module fdcs_trace_mem (
    input wire logic clk_in,
    input wire logic we_in,
    input wire logic [8:0] waddr_in,
    input wire logic [15:0] wdata_in,
    input wire logic [8:0] raddr_in,
    output logic [15:0] rdata_out
);
    logic [15:0] mem [0:511];

    // write port
    always_ff @(posedge clk_in) begin
        if (we_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    // read port
    always_ff @(posedge clk_in) begin
        rdata_out <= mem[raddr_in];
    end
endmodule
`default_nettype wire

// ==== design/fdcs_top.sv ====
// demodulator control, status, trace capture and bit output
`timescale 1ns/1ps
`default_nettype none
`include "fdcs_params.svh"
module fdcs_top (
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    input wire fdcs_pkg::fdcs_stat_type STATUS_IN,
    input wire logic CARRIER_MSB_IN,
    input wire logic BIT_TIMING_IN,
    input wire logic [9:0] SAMPLE_I_IN,
    input wire logic [9:0] SAMPLE_Q_IN,
    input wire logic [39:0] TRACE1_IN,
    input wire logic [39:0] TRACE2_IN,
    input wire logic TRACE_TICK_IN,
    input wire logic SYM_VALID_IN,
    input wire logic signed [3:0] SYM_LEVEL_IN,
    output logic SYM_READY_OUT,
    input wire logic DATA_READY_IN,
    output logic DATA_OUT,
    output logic DATA_STROBE_OUT,
    input wire logic [3:0] BUS_ADDR_IN,
    input wire logic BUS_RD_IN,
    output logic BUS_OE_N_OUT,
    output logic AFC_ENABLE_OUT,
    output logic [1:0] MARY_OUT,
    output logic INPUT_UNSIGNED_OUT,
    output logic SPECTRUM_INV_OUT,
    output logic TP_LOCK_OUT,
    output logic TP_DETECT_OUT,
    output logic TP_CARRIER_OUT,
    output logic TP_BIT_TIMING_OUT,
    output logic TP_SAT_OUT,
    output logic TP_CLOCK_OUT
);
    logic [7:0] ctrl_reg;
    logic [7:0] baddr_reg;
    logic [7:0] tctl_reg;
    logic [7:0] tdec_reg;
    logic [8:0] tra_reg;
    fdcs_pkg::fdcs_stat_type snap_reg;
    fdcs_pkg::fdcs_cap_type cap_reg;
    logic [8:0] waddr_reg;
    logic [7:0] dec_reg;
    logic [15:0] trace_rdata;
    logic [7:0] tr1_sel;
    logic [7:0] tr2_sel;
    logic arm;
    logic trig;
    logic tick;
    logic take;
    logic [7:0] rdata_next;
    logic [2:0] sym_reg;
    logic [1:0] left_reg;
    logic [1:0] left_next;
    logic [1:0] nbits;
    logic [4:0] ofs;
    logic [4:0] code_sum;
    logic accept;
    logic push;
    logic pop;
    logic bit_in;
    logic [1:0] cnt_reg;
    logic e0_reg;
    logic e1_reg;
    logic rd_s1_reg;
    logic rd_s2_reg;
    logic rd_s3_reg;
    logic [3:0] addr_s1_reg;
    logic [3:0] addr_s2_reg;
    logic bus_mode;
    logic bus_hit;
    logic sink_rdy;
    logic [3:0] tpdiv_reg;

    assign bus_mode = ctrl_reg[`FDCS_B_BUSMODE];

    // software writes to the control registers; status offsets ignored
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            ctrl_reg <= `FDCS_CTRL_RST;
            baddr_reg <= `FDCS_ZERO8;
            tctl_reg <= `FDCS_ZERO8;
            tdec_reg <= `FDCS_ZERO8;
            tra_reg <= '0;
        end else if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                `FDCS_A_CTRL: ctrl_reg <= REG_WDATA_IN;
                `FDCS_A_BADDR: baddr_reg <= REG_WDATA_IN;
                `FDCS_A_TCTL: tctl_reg <= REG_WDATA_IN;
                `FDCS_A_TDEC: tdec_reg <= REG_WDATA_IN;
                `FDCS_A_TRA_LO: tra_reg[7:0] <= REG_WDATA_IN;
                `FDCS_A_TRA_HI: tra_reg[8] <= REG_WDATA_IN[0];
                default: ; // R10
            endcase
        end
    end

    // mode bits toward the signal path
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            AFC_ENABLE_OUT <= 1'b0;
            MARY_OUT <= 2'b00;
            INPUT_UNSIGNED_OUT <= 1'b0;
            SPECTRUM_INV_OUT <= 1'b0;
        end else begin
            AFC_ENABLE_OUT <= ~ctrl_reg[`FDCS_B_AFC_DIS]; // R1
            MARY_OUT <= ctrl_reg[`FDCS_F_MARY];
            INPUT_UNSIGNED_OUT <= ctrl_reg[`FDCS_B_UNSIGNED];
            SPECTRUM_INV_OUT <= ctrl_reg[`FDCS_B_SPINV];
        end
    end

    // monitoring snapshot follows the path only while updates run
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            snap_reg <= '0;
        end else if (ctrl_reg[`FDCS_B_RUN]) begin
            snap_reg <= STATUS_IN; // R3
        end
    end

    // register read mux, unmapped offsets read zero
    always_comb begin
        rdata_next = `FDCS_ZERO8;
        unique case (REG_ADDR_IN)
            `FDCS_A_CTRL: rdata_next = ctrl_reg;
            `FDCS_A_BADDR: rdata_next = baddr_reg;
            `FDCS_A_OFS_LO: rdata_next = snap_reg.offset[7:0]; // R6
            `FDCS_A_OFS_MID: rdata_next = snap_reg.offset[15:8]; // R6
            `FDCS_A_OFS_HI: rdata_next = snap_reg.offset[23:16]; // R6
            `FDCS_A_MAG: rdata_next = snap_reg.magnitude; // R7
            `FDCS_A_LOCK: begin
                rdata_next[0] = snap_reg.lock; // R8
                rdata_next[1] = snap_reg.detect; // R9
            end
            `FDCS_A_TCTL: rdata_next = tctl_reg;
            `FDCS_A_TDEC: rdata_next = tdec_reg;
            `FDCS_A_TRA_LO: rdata_next = tra_reg[7:0];
            `FDCS_A_TRA_HI: rdata_next[0] = tra_reg[8];
            `FDCS_A_TSTAT: rdata_next[1:0] = cap_reg;
            `FDCS_A_TD1: rdata_next = trace_rdata[7:0];
            `FDCS_A_TD2: rdata_next = trace_rdata[15:8];
            default: rdata_next = `FDCS_ZERO8;
        endcase
    end

    // read answer one cycle after the strobe
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            REG_RDATA_OUT <= `FDCS_ZERO8;
            REG_RVALID_OUT <= 1'b0;
        end else begin
            REG_RVALID_OUT <= REG_RD_IN;
            if (REG_RD_IN) begin
                REG_RDATA_OUT <= rdata_next;
            end
        end
    end

    // test points: live lock, detect, carrier, timing, saturation
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            TP_LOCK_OUT <= 1'b0;
            TP_DETECT_OUT <= 1'b0;
            TP_CARRIER_OUT <= 1'b0;
            TP_BIT_TIMING_OUT <= 1'b0;
            TP_SAT_OUT <= 1'b0;
        end else begin
            TP_LOCK_OUT <= STATUS_IN.lock; // R8
            TP_DETECT_OUT <= STATUS_IN.detect; // R9
            TP_CARRIER_OUT <= CARRIER_MSB_IN; // R11
            TP_BIT_TIMING_OUT <= BIT_TIMING_IN; // R13
            TP_SAT_OUT <= (&SAMPLE_I_IN) | (~|SAMPLE_I_IN) |
                          (&SAMPLE_Q_IN) | (~|SAMPLE_Q_IN); // R12
        end
    end

    // processing clock image from a toggle divider
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            tpdiv_reg <= 4'h0;
            TP_CLOCK_OUT <= 1'b0;
        end else if (tpdiv_reg == 4'(`FDCS_TPCLK_HALF - 1)) begin
            tpdiv_reg <= 4'h0;
            TP_CLOCK_OUT <= ~TP_CLOCK_OUT; // R13
        end else begin
            tpdiv_reg <= tpdiv_reg + 4'h1;
        end
    end

    // trace source select, codes above four pick the first source
    always_comb begin
        tr1_sel = TRACE1_IN[7:0];
        tr2_sel = TRACE2_IN[7:0];
        if (tctl_reg[`FDCS_F_SEL1] <= `FDCS_SEL_MAX) begin
            tr1_sel = TRACE1_IN[tctl_reg[`FDCS_F_SEL1] * 8 +: 8]; // R14
        end
        if (tctl_reg[`FDCS_F_SEL2] <= `FDCS_SEL_MAX) begin
            tr2_sel = TRACE2_IN[tctl_reg[`FDCS_F_SEL2] * 8 +: 8]; // R14
        end
    end

    // capture pacing: trigger source, clock choice, decimation
    assign arm = REG_WR_IN && (REG_ADDR_IN == `FDCS_A_TSTAT);
    assign trig = tctl_reg[`FDCS_B_TRIG] ? STATUS_IN.detect
                                          : STATUS_IN.lock; // R14
    assign tick = tctl_reg[`FDCS_B_FCLK] | TRACE_TICK_IN; // R15
    assign take = (cap_reg == fdcs_pkg::FDCS_CAP_RUN) && tick &&
                  (dec_reg == `FDCS_ZERO8); // R15

    // decimation counter reloads from the software factor
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN || arm) begin
            dec_reg <= `FDCS_ZERO8;
        end else if (tick && cap_reg == fdcs_pkg::FDCS_CAP_RUN) begin
            if (dec_reg == `FDCS_ZERO8) begin
                dec_reg <= tdec_reg; // R15
            end else begin
                dec_reg <= dec_reg - 8'h01;
            end
        end
    end

    // capture sequence: arm, wait trigger, fill 512 samples
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            cap_reg <= fdcs_pkg::FDCS_CAP_IDLE;
            waddr_reg <= '0;
        end else if (arm) begin
            cap_reg <= fdcs_pkg::FDCS_CAP_ARMED;
            waddr_reg <= '0;
        end else begin
            unique case (cap_reg)
                fdcs_pkg::FDCS_CAP_IDLE: ;
                fdcs_pkg::FDCS_CAP_ARMED: begin
                    if (trig) begin
                        cap_reg <= fdcs_pkg::FDCS_CAP_RUN; // R14
                    end
                end
                fdcs_pkg::FDCS_CAP_RUN: begin
                    if (take) begin
                        waddr_reg <= waddr_reg + 9'h001;
                        if (waddr_reg == `FDCS_TR_LAST) begin
                            cap_reg <= fdcs_pkg::FDCS_CAP_DONE; // R14
                        end
                    end
                end
                fdcs_pkg::FDCS_CAP_DONE: ;
            endcase
        end
    end

    fdcs_trace_mem u_mem (
        .clk_in(MCLK_IN),
        .we_in(take),
        .waddr_in(waddr_reg),
        .wdata_in({tr2_sel, tr1_sel}),
        .raddr_in(tra_reg),
        .rdata_out(trace_rdata)
    );

    // symbol to bit group: code = (level + M - 1) / 2
    always_comb begin
        unique case (fdcs_pkg::fdcs_mary_type'(ctrl_reg[`FDCS_F_MARY]))
            fdcs_pkg::FDCS_M4: begin
                ofs = `FDCS_OFS4; // R19
                nbits = `FDCS_NB2; // R22
            end
            fdcs_pkg::FDCS_M8: begin
                ofs = `FDCS_OFS8; // R19 R21
                nbits = `FDCS_NB3; // R22
            end
            default: begin
                ofs = `FDCS_OFS2; // R17
                nbits = `FDCS_NB1; // R22
            end
        endcase
        code_sum = {SYM_LEVEL_IN[3], SYM_LEVEL_IN} + ofs; // R20
    end

    // serializer hands bits to the buffer, MSB first
    assign accept = SYM_VALID_IN && SYM_READY_OUT;
    assign bit_in = sym_reg[left_reg - 2'h1]; // R18
    assign push = (left_reg != 2'h0) && ((cnt_reg != 2'h2) || pop);
    always_comb begin
        left_next = left_reg;
        if (accept) begin
            left_next = nbits;
        end else if (push) begin
            left_next = left_reg - 2'h1;
        end
    end

    // symbols join one unbroken stream, no per-symbol restart
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            sym_reg <= 3'h0;
            left_reg <= 2'h0;
            SYM_READY_OUT <= 1'b0;
        end else begin
            if (accept) begin
                sym_reg <= code_sum[3:1]; // R16 R17 R19 R21
            end
            left_reg <= left_next;
            SYM_READY_OUT <= (left_next == 2'h0);
        end
    end

    // bus pins are sampled twice before use
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            rd_s1_reg <= 1'b0;
            rd_s2_reg <= 1'b0;
            rd_s3_reg <= 1'b0;
            addr_s1_reg <= 4'h0;
            addr_s2_reg <= 4'h0;
        end else begin
            rd_s1_reg <= BUS_RD_IN;
            rd_s2_reg <= rd_s1_reg;
            rd_s3_reg <= rd_s2_reg;
            addr_s1_reg <= BUS_ADDR_IN;
            addr_s2_reg <= addr_s1_reg;
        end
    end

    // read edge for this slave only; direct mode ignores address
    assign bus_hit = rd_s2_reg && !rd_s3_reg &&
                     (addr_s2_reg == baddr_reg[`FDCS_F_ADDR]); // R4
    assign sink_rdy = bus_mode ? bus_hit : DATA_READY_IN; // R23
    assign pop = (cnt_reg != 2'h0) && sink_rdy;

    // two-entry bit buffer between serializer and sink
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            cnt_reg <= 2'h0;
            e0_reg <= 1'b0;
            e1_reg <= 1'b0;
        end else begin
            unique case ({push, pop})
                2'b10: begin
                    if (cnt_reg == 2'h0) begin
                        e0_reg <= bit_in;
                    end else begin
                        e1_reg <= bit_in;
                    end
                    cnt_reg <= cnt_reg + 2'h1;
                end
                2'b01: begin
                    e0_reg <= e1_reg;
                    cnt_reg <= cnt_reg - 2'h1;
                end
                2'b11: begin
                    if (cnt_reg == 2'h1) begin
                        e0_reg <= bit_in;
                    end else begin
                        e0_reg <= e1_reg;
                        e1_reg <= bit_in;
                    end
                end
                2'b00: ;
            endcase
        end
    end

    // output stage with squelch and bus drive enable
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            DATA_OUT <= 1'b1;
            DATA_STROBE_OUT <= 1'b0;
            BUS_OE_N_OUT <= 1'b1;
        end else begin
            DATA_STROBE_OUT <= pop;
            BUS_OE_N_OUT <= ~(bus_mode && bus_hit); // R4 R23
            if (pop) begin
                DATA_OUT <= (ctrl_reg[`FDCS_B_SQL] &&
                             !STATUS_IN.detect) ? 1'b1 : e0_reg; // R2
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/fdcs_sink_model.sv ====
// decoder side model: takes strobed bits and stalls on request
`timescale 1ns/1ps
`default_nettype none
module fdcs_sink_model (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic slow_in,
    input wire logic data_in,
    input wire logic strobe_in,
    output logic ready_out,
    output logic [15:0] bits_out,
    output logic [7:0] count_out
);
    // ready drops every other cycle when slow
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= !slow_in || !ready_out;
        end
    end
    // shift in strobed bits, first bit ends highest
    always_ff @(posedge clk_in) begin
        if (!rstn_in) begin
            bits_out <= 16'h0000;
            count_out <= 8'h00;
        end else if (strobe_in) begin
            bits_out <= {bits_out[14:0], data_in};
            count_out <= count_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== bench/fdcs_top_chk.sv ====
// port assertions of the demodulator control block
`timescale 1ns/1ps
`default_nettype none
module fdcs_top_chk (
    input wire logic MCLK_IN,
    input wire logic RESETN_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic REG_RVALID_OUT,
    input wire fdcs_pkg::fdcs_stat_type STATUS_IN,
    input wire logic [9:0] SAMPLE_I_IN,
    input wire logic [9:0] SAMPLE_Q_IN,
    input wire logic SYM_VALID_IN,
    input wire logic SYM_READY_OUT,
    input wire logic DATA_OUT,
    input wire logic DATA_STROBE_OUT,
    input wire logic BUS_OE_N_OUT,
    input wire logic AFC_ENABLE_OUT,
    input wire logic [1:0] MARY_OUT,
    input wire logic TP_LOCK_OUT,
    input wire logic TP_DETECT_OUT,
    input wire logic TP_SAT_OUT
);
    logic [7:0] ctrl_reg;
    logic sat;
    // mode register shadow
    always_ff @(posedge MCLK_IN) begin
        if (!RESETN_IN) begin
            ctrl_reg <= 8'h80;
        end else if (REG_WR_IN && REG_ADDR_IN == 8'h08) begin
            ctrl_reg <= REG_WDATA_IN;
        end
    end
    // input saturation
    assign sat = &SAMPLE_I_IN || ~|SAMPLE_I_IN
        || &SAMPLE_Q_IN || ~|SAMPLE_Q_IN;
    default clocking cb @(posedge MCLK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    a_afc_from_mode: assert property (
        REG_WR_IN && REG_ADDR_IN == 8'h08 |-> ##2
        AFC_ENABLE_OUT == !$past(REG_WDATA_IN[5], 2))
        else $error("afc enable does not follow mode write");
    a_mary_from_mode: assert property (
        REG_WR_IN && REG_ADDR_IN == 8'h08 |-> ##2
        MARY_OUT == $past(REG_WDATA_IN[1:0], 2))
        else $error("alphabet size does not follow mode write");
    a_read_answer: assert property (
        REG_RVALID_OUT == $past(REG_RD_IN))
        else $error("read answer pulse wrong");
    a_symbol_taken: assert property (
        SYM_VALID_IN && SYM_READY_OUT |=> !SYM_READY_OUT)
        else $error("symbol ready did not drop after accept");
    a_status_points: assert property (
        $past(RESETN_IN) |-> TP_LOCK_OUT == $past(STATUS_IN.lock)
        && TP_DETECT_OUT == $past(STATUS_IN.detect))
        else $error("lock or detect test point wrong");
    a_sat_point: assert property (
        $past(RESETN_IN) |-> TP_SAT_OUT == $past(sat))
        else $error("saturation test point wrong");
    a_squelch_one: assert property (
        DATA_STROBE_OUT && $past(ctrl_reg[6])
        && !$past(STATUS_IN.detect) |-> DATA_OUT)
        else $error("squelched bit not forced to one");
    a_direct_no_drive: assert property (
        !ctrl_reg[4] && !$past(ctrl_reg[4], 6) |-> BUS_OE_N_OUT)
        else $error("bus driven in direct mode");
    a_drive_one_cycle: assert property (
        $fell(BUS_OE_N_OUT) |=> BUS_OE_N_OUT)
        else $error("bus drive longer than one cycle");
endmodule
`default_nettype wire

// ==== bench/fdcs_top_tb_top.sv ====
// testbench of the demodulator control and status block
`timescale 1ns/1ps
`default_nettype none
module fdcs_top_tb_top;
    logic MCLK_IN, RESETN_IN, REG_WR_IN, REG_RD_IN, REG_RVALID_OUT;
    logic [7:0] REG_ADDR_IN, REG_WDATA_IN, REG_RDATA_OUT;
    fdcs_pkg::fdcs_stat_type STATUS_IN;
    logic CARRIER_MSB_IN, BIT_TIMING_IN, TRACE_TICK_IN, SYM_VALID_IN;
    logic [9:0] SAMPLE_I_IN = 10'h000, SAMPLE_Q_IN;
    logic [39:0] TRACE1_IN, TRACE2_IN;
    logic signed [3:0] SYM_LEVEL_IN;
    logic SYM_READY_OUT, DATA_READY_IN, DATA_OUT, DATA_STROBE_OUT;
    logic BUS_RD_IN, BUS_OE_N_OUT, AFC_ENABLE_OUT, INPUT_UNSIGNED_OUT;
    logic SPECTRUM_INV_OUT, TP_LOCK_OUT, TP_DETECT_OUT, TP_CARRIER_OUT;
    logic TP_BIT_TIMING_OUT, TP_SAT_OUT, TP_CLOCK_OUT, slow;
    logic [3:0] BUS_ADDR_IN;
    logic [1:0] MARY_OUT;
    logic [15:0] rx_bits;
    logic [7:0] rx_cnt;
    int errors, checked, cyc;

    fdcs_top i_fdcs_top (.*);
    fdcs_sink_model i_fdcs_sink_model (.clk_in(MCLK_IN),
        .rstn_in(RESETN_IN), .slow_in(slow), .data_in(DATA_OUT),
        .strobe_in(DATA_STROBE_OUT), .ready_out(DATA_READY_IN),
        .bits_out(rx_bits), .count_out(rx_cnt));

    // clock and sample ramp
    initial begin
        MCLK_IN = 1'b0;
        forever #2.5 MCLK_IN = ~MCLK_IN;
    end
    always @(negedge MCLK_IN) begin
        SAMPLE_I_IN <= SAMPLE_I_IN + 10'h001;
    end
    assign CARRIER_MSB_IN = SAMPLE_I_IN[2];
    assign BIT_TIMING_IN = SAMPLE_I_IN[4];
    assign TRACE_TICK_IN = SAMPLE_I_IN[0];
    // cut a hang short
    always @(posedge MCLK_IN) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    // compare and count
    task chk(input string n, input logic [23:0] got, exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s exp %h got %h", n, exp, got);
        end
    endtask
    task results;
        if (errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // register write and read-compare, one strobe cycle each
    task wr(input logic [7:0] a, d);
        @(negedge MCLK_IN);
        REG_ADDR_IN = a;
        REG_WDATA_IN = d;
        REG_WR_IN = 1'b1;
        @(negedge MCLK_IN);
        REG_WR_IN = 1'b0;
    endtask
    task rchk(input logic [7:0] a, exp);
        @(negedge MCLK_IN);
        REG_ADDR_IN = a;
        REG_RD_IN = 1'b1;
        @(negedge MCLK_IN);
        REG_RD_IN = 1'b0;
        chk($sformatf("reg %h", a), REG_RDATA_OUT, exp);
    endtask
    // send one symbol and wait for its bits at the sink
    task sym(input logic [3:0] lv, input int nb, input logic [23:0] exp);
        int i;
        int c0;
        c0 = rx_cnt;
        for (i = 0; i < 60 && SYM_READY_OUT !== 1'b1; i++) begin
            @(negedge MCLK_IN);
        end
        SYM_LEVEL_IN = lv;
        SYM_VALID_IN = 1'b1;
        @(negedge MCLK_IN);
        SYM_VALID_IN = 1'b0;
        for (i = 0; i < 60 && rx_cnt - c0 < nb; i++) begin
            @(negedge MCLK_IN);
        end
        chk("bits", 24'(rx_bits) & 24'((1 << nb) - 1), exp);
    endtask
    // shared bus read; records drive, strobe and bit seen
    task busrd(input logic [3:0] a, input logic [2:0] exp);
        int i;
        logic [2:0] seen;
        seen = 3'b000;
        BUS_ADDR_IN = a;
        @(negedge MCLK_IN);
        BUS_RD_IN = 1'b1;
        for (i = 0; i < 10; i++) begin
            @(negedge MCLK_IN);
            seen[2] = seen[2] | (BUS_OE_N_OUT === 1'b0);
            if (DATA_STROBE_OUT === 1'b1) begin
                seen[1:0] = {1'b1, DATA_OUT};
            end
        end
        BUS_RD_IN = 1'b0;
        repeat (3) @(negedge MCLK_IN);
        chk("bus", seen, exp);
    endtask

    // mode and address registers, unmapped place
    task t_regs;
        chk("afc", AFC_ENABLE_OUT, 1'b1);
        chk("tp", {TP_CARRIER_OUT, TP_BIT_TIMING_OUT, TP_CLOCK_OUT},
            {SAMPLE_I_IN[2], SAMPLE_I_IN[4], ~SAMPLE_I_IN[0]});
        rchk(8'h08, 8'h80);
        wr(8'h08, 8'hAD);
        repeat (2) @(negedge MCLK_IN);
        chk("afc", AFC_ENABLE_OUT, 1'b0);
        chk("mary", {MARY_OUT, INPUT_UNSIGNED_OUT, SPECTRUM_INV_OUT},
            4'b0111);
        rchk(8'h08, 8'hAD);
        wr(8'h09, 8'h05);
        rchk(8'h09, 8'h05);
        rchk(8'h30, 8'h00);
        wr(8'h08, 8'h80);
    endtask
    // status bytes, a write to them, then freeze and resume
    task t_status;
        STATUS_IN = {24'hA5_5A3C, 8'hC7, 1'b1, 1'b0};
        repeat (3) @(negedge MCLK_IN);
        rchk(8'h0C, 8'h3C);
        rchk(8'h0E, 8'hA5);
        rchk(8'h0F, 8'hC7);
        rchk(8'h10, 8'h01);
        wr(8'h0C, 8'hFF);
        rchk(8'h0C, 8'h3C);
        wr(8'h08, 8'h00);
        repeat (2) @(negedge MCLK_IN);
        STATUS_IN = {24'h12_3456, 8'h21, 1'b0, 1'b1};
        repeat (3) @(negedge MCLK_IN);
        rchk(8'h0D, 8'h5A);
        rchk(8'h10, 8'h01);
        wr(8'h08, 8'h80);
        repeat (3) @(negedge MCLK_IN);
        rchk(8'h0D, 8'h34);
        rchk(8'h10, 8'h02);
    endtask
    // every level of every alphabet, sink stalling every other cycle
    task t_symbols;
        int m;
        int k;
        int lv;
        slow = 1'b1;
        for (m = 0; m < 3; m++) begin
            wr(8'h08, 8'h80 | 8'(m));
            for (k = 0; k < (2 << m); k++) begin
                lv = 2 * k + 1 - (2 << m);
                sym(4'(lv), m + 1, 24'(k));
            end
        end
        slow = 1'b0;
    endtask
    // squelch with weak and present signal, and switched off
    task t_squelch;
        wr(8'h08, 8'hC0);
        STATUS_IN.detect = 1'b0;
        sym(4'hF, 1, 24'h1);
        STATUS_IN.detect = 1'b1;
        sym(4'hF, 1, 24'h0);
        wr(8'h08, 8'h80);
        STATUS_IN.detect = 1'b0;
        sym(4'hF, 1, 24'h0);
    endtask
    // shared bus: foreign address, own address, empty, direct mode
    task t_bus;
        wr(8'h08, 8'h90);
        sym(4'h1, 0, 24'h0);
        busrd(4'h3, 3'b000);
        busrd(4'h5, 3'b111);
        busrd(4'h5, 3'b100);
        wr(8'h08, 8'h80);
        busrd(4'h5, 3'b000);
    endtask
    // capture on lock at every master clock cycle, decimated by two
    task t_trace;
        wr(8'h11, 8'hA2);
        wr(8'h12, 8'h01);
        wr(8'h15, 8'h00);
        rchk(8'h15, 8'h01);
        STATUS_IN.lock = 1'b1;
        repeat (600) @(negedge MCLK_IN);
        rchk(8'h15, 8'h02);
        repeat (600) @(negedge MCLK_IN);
        rchk(8'h15, 8'h03);
        wr(8'h13, 8'h00);
        wr(8'h14, 8'h00);
        repeat (2) @(negedge MCLK_IN);
        rchk(8'h16, 8'h33);
        rchk(8'h17, 8'h99);
    endtask

    // reset, then the scenarios in turn
    initial begin
        RESETN_IN = 1'b0;
        {REG_WR_IN, REG_RD_IN, SYM_VALID_IN, BUS_RD_IN, slow} = '0;
        {REG_ADDR_IN, REG_WDATA_IN, SYM_LEVEL_IN, BUS_ADDR_IN} = '0;
        STATUS_IN = '0;
        SAMPLE_Q_IN = 10'h155;
        TRACE1_IN = 40'h55_4433_2211;
        TRACE2_IN = 40'h99_8877_6655;
        repeat (2) @(negedge MCLK_IN);
        RESETN_IN = 1'b1;
        repeat (3) @(negedge MCLK_IN);
        t_regs();
        t_status();
        t_symbols();
        t_squelch();
        t_bus();
        t_trace();
        results();
    end
endmodule

bind fdcs_top fdcs_top_chk i_fdcs_top_chk (.*);
`default_nettype wire
